// ### core/drive_status_register_map.sv
// holding register bank of the drive: status words, readings, parameters
// assumes a serial protocol engine that hands over one register per request
// and frames the answer; switch and input pins arrive unsynchronised
`timescale 1ns/1ps
module drive_status_register_map (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // request from the protocol engine
   input wire logic req_valid,
   input wire drive_regs_pkg::req_t req,
   output logic req_ready,
   // answer to the protocol engine
   output logic rsp_valid,
   output drive_regs_pkg::rsp_t rsp,
   // drive conditions and measurements
   input wire drive_regs_pkg::drive_cond_t drive_cond,
   input wire drive_regs_pkg::io_cond_t io_cond,
   input wire drive_regs_pkg::meas_t meas,
   input wire logic [15:0] minimum_speed_param,
   // unsynchronised pins
   input wire logic digital_input_one,
   input wire logic digital_input_two,
   input wire logic digital_input_three,
   input wire logic digital_input_four,
   input wire logic fwd_switch,
   input wire logic rev_switch
);
   import drive_regs_pkg::*;

   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_clean;
   logic [15:0] param_mem [PARAM_COUNT];
   logic toggle_reg;
   logic toggle_next;
   logic rsp_valid_reg;
   logic rsp_valid_next;
   rsp_t rsp_reg;
   rsp_t rsp_next;
   logic wr_en;
   logic [5:0] wr_idx;
   logic [5:0] req_idx;
   logic in_param;
   logic [15:0] rel_addr;
   logic [15:0] drive_word;
   logic [15:0] pin_word;
   logic [15:0] abs_speed;
   logic speed_neg;

   assign pin_raw = {rev_switch, fwd_switch, digital_input_four,
      digital_input_three, digital_input_two, digital_input_one};

   // three stages; a change counts only once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         logic [2:0] sync_reg;
         logic [2:0] sync_next;
         logic clean_reg;
         logic clean_next;
         always_comb begin
            sync_next = {sync_reg[1:0], pin_raw[gi]};
            clean_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2]
               : clean_reg;
         end
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               sync_reg <= 3'h0;
               clean_reg <= 1'b0;
            end else begin
               sync_reg <= sync_next;
               clean_reg <= clean_next;
            end
         end
         assign pin_clean[gi] = clean_reg;
      end
   endgenerate

   // one register per request, answered the next cycle, never stalled
   assign req_ready = 1'b1;
   assign rsp_valid = rsp_valid_reg;
   assign rsp = rsp_reg;

   assign speed_neg = meas.speed[15];
   assign abs_speed = speed_neg ? 16'(-meas.speed) : meas.speed;

   always_comb begin
      drive_word = 16'h0000;
      drive_word[DS_READY] = !drive_cond.tripped && !drive_cond.supply_loss
         && drive_cond.hw_enable;
      drive_word[DS_RUNNING] = drive_cond.running;
      drive_word[DS_TRIPPED] = drive_cond.tripped;
      drive_word[DS_STANDBY] = drive_cond.standby;
      drive_word[DS_OVERRIDE] = drive_cond.override_mode;
      drive_word[DS_AT_SPEED] = drive_cond.enabled
         && (meas.speed == meas.setpoint);
      drive_word[DS_BELOW_MIN] = drive_cond.enabled
         && (abs_speed < minimum_speed_param);
      drive_word[DS_OVERLOAD] = meas.current > param_mem[RATED_CURRENT_IDX];
      drive_word[DS_SUPPLY_LOSS] = drive_cond.supply_loss;
      drive_word[DS_HEATSINK_HOT] = meas.heatsink > HEATSINK_LIMIT;
      drive_word[DS_BOARD_HOT] = meas.board_temp > BOARD_LIMIT;
      drive_word[DS_FOLDBACK] = drive_cond.foldback;
      drive_word[DS_REVERSE] = speed_neg;
      // alive bit shows value before this read
      drive_word[DS_TOGGLE] = toggle_reg;
   end

   always_comb begin
      pin_word = 16'h0000;
      // digital inputs, input one at bit 0
      pin_word[PS_DIN_LOW +: 4] = pin_clean[3:0];
      pin_word[PS_FWD_SW] = pin_clean[4];
      pin_word[PS_REV_SW] = pin_clean[5];
      pin_word[PS_OUT_ACTIVE] = io_cond.dout_active || (meas.aout != 16'h0000);
      pin_word[PS_RELAY] = io_cond.relay_closed;
      // loss only counts in current loop mode
      pin_word[PS_AIN_ONE_LOST] = io_cond.ain_one_loop && io_cond.ain_one_lost;
      pin_word[PS_AIN_TWO_LOST] = io_cond.ain_two_loop && io_cond.ain_two_lost;
      pin_word[PS_KNOB_HIGH] = meas.knob > KNOB_HALF;
   end

   assign rel_addr = req.addr - PARAM_BASE;
   assign in_param = (rel_addr >= PARAM_FIRST) && (rel_addr <= PARAM_LAST)
      && (req.addr >= PARAM_BASE);
   assign req_idx = 6'(rel_addr - PARAM_FIRST);

   always_comb begin
      rsp_next = rsp_reg;
      rsp_valid_next = 1'b0;
      toggle_next = toggle_reg;
      wr_en = 1'b0;
      wr_idx = req_idx;
      if (req_valid) begin
         rsp_valid_next = 1'b1;
         rsp_next.data = 16'h0000;
         rsp_next.exc = EXC_NONE;
         case (req.func)
            // reads answered for all readable registers
            FC_READ: begin
               if (in_param) begin
                  rsp_next.data = param_mem[req_idx];
               end else begin
                  case (req.addr)
                     REG_DRIVE_STATE: begin
                        rsp_next.data = drive_word;
                        toggle_next = !toggle_reg;
                     end
                     REG_SPEED: rsp_next.data = meas.speed;
                     REG_CURRENT: rsp_next.data = meas.current;
                     REG_POWER: rsp_next.data = meas.power;
                     REG_PIN_STATE: rsp_next.data = pin_word;
                     REG_TORQUE: rsp_next.data = meas.torque;
                     REG_BUS_VOLT: rsp_next.data = meas.bus_volt;
                     REG_HEATSINK: rsp_next.data = meas.heatsink;
                     REG_AIN_ONE: rsp_next.data = meas.ain_one;
                     REG_AIN_TWO: rsp_next.data = meas.ain_two;
                     REG_AOUT: rsp_next.data = meas.aout;
                     REG_LOOP_OUT: rsp_next.data = meas.loop_out;
                     REG_BOARD_TEMP: rsp_next.data = meas.board_temp;
                     REG_MOTOR_VOLT: rsp_next.data = meas.motor_volt;
                     REG_KNOB: rsp_next.data = meas.knob;
                     REG_FAULT: rsp_next.data = meas.fault;
                     default: rsp_next.exc = EXC_BAD_ADDR;
                  endcase
               end
            end
            FC_WRITE: begin
               if (in_param) begin
                  wr_en = 1'b1;
                  rsp_next.data = req.wdata;
               end else if (req.addr >= REG_DRIVE_STATE
                  && req.addr <= REG_FAULT) begin
                  rsp_next.data = req.wdata;
               end else begin
                  rsp_next.exc = EXC_BAD_ADDR;
               end
            end
            // multi-write belongs to the low control block only
            default: rsp_next.exc = EXC_BAD_FUNC;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         toggle_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_reg <= '0;
      end else begin
         toggle_reg <= toggle_next;
         rsp_valid_reg <= rsp_valid_next;
         rsp_reg <= rsp_next;
      end
   end

   // parameters reset to zero; loading defaults is firmware's job
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < PARAM_COUNT; i++) begin
            param_mem[i] <= PARAM_RESET;
         end
      end else if (wr_en) begin
         param_mem[wr_idx] <= req.wdata;
      end
   end
endmodule

// ### core/drive_regs_pkg.sv
// drive status register map: addresses, bit positions, limits, carriers
// shared by the register bank and whatever bench drives it
package drive_regs_pkg;
   // holding register numbers of the read-only status block
   localparam logic [15:0] REG_DRIVE_STATE = 16'h07D1;
   localparam logic [15:0] REG_SPEED = 16'h07D2;
   localparam logic [15:0] REG_CURRENT = 16'h07D3;
   localparam logic [15:0] REG_POWER = 16'h07D4;
   localparam logic [15:0] REG_PIN_STATE = 16'h07D5;
   localparam logic [15:0] REG_TORQUE = 16'h07D6;
   localparam logic [15:0] REG_BUS_VOLT = 16'h07D7;
   localparam logic [15:0] REG_HEATSINK = 16'h07D8;
   localparam logic [15:0] REG_AIN_ONE = 16'h07D9;
   localparam logic [15:0] REG_AIN_TWO = 16'h07DA;
   localparam logic [15:0] REG_AOUT = 16'h07DB;
   localparam logic [15:0] REG_LOOP_OUT = 16'h07DC;
   localparam logic [15:0] REG_BOARD_TEMP = 16'h07DD;
   localparam logic [15:0] REG_MOTOR_VOLT = 16'h07DE;
   localparam logic [15:0] REG_KNOB = 16'h07DF;
   localparam logic [15:0] REG_FAULT = 16'h07E0;
   // adjustable parameters sit at base plus parameter number
   localparam logic [15:0] PARAM_BASE = 16'h0080;
   localparam logic [15:0] PARAM_FIRST = 16'h0004;
   localparam logic [15:0] PARAM_LAST = 16'h003C;
   localparam int PARAM_COUNT = 57;
   localparam logic [5:0] RATED_CURRENT_IDX = 6'h04;
   localparam logic [15:0] PARAM_RESET = 16'h0000;
   // function and exception codes
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_WRITE = 8'h06;
   localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
   localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
   // drive state word bits
   localparam int DS_READY = 0;
   localparam int DS_RUNNING = 1;
   localparam int DS_TRIPPED = 2;
   localparam int DS_STANDBY = 3;
   localparam int DS_OVERRIDE = 4;
   localparam int DS_AT_SPEED = 6;
   localparam int DS_BELOW_MIN = 7;
   localparam int DS_OVERLOAD = 8;
   localparam int DS_SUPPLY_LOSS = 9;
   localparam int DS_HEATSINK_HOT = 10;
   localparam int DS_BOARD_HOT = 11;
   localparam int DS_FOLDBACK = 12;
   localparam int DS_REVERSE = 13;
   localparam int DS_TOGGLE = 15;
   // pin state word bits
   localparam int PS_DIN_LOW = 0;
   localparam int PS_FWD_SW = 6;
   localparam int PS_REV_SW = 7;
   localparam int PS_OUT_ACTIVE = 8;
   localparam int PS_RELAY = 9;
   localparam int PS_AIN_ONE_LOST = 12;
   localparam int PS_AIN_TWO_LOST = 13;
   localparam int PS_KNOB_HIGH = 15;
   // thresholds, degrees C and raw counts
   localparam logic [15:0] HEATSINK_LIMIT = 16'h0055;
   localparam logic [15:0] BOARD_LIMIT = 16'h0050;
   localparam logic [15:0] KNOB_HALF = 16'h0800;
   localparam int PIN_COUNT = 6;

   typedef struct packed {
      logic tripped;
      logic supply_loss;
      logic hw_enable;
      logic running;
      logic standby;
      logic override_mode;
      logic enabled;
      logic foldback;
   } drive_cond_t;

   typedef struct packed {
      logic dout_active;
      logic relay_closed;
      logic ain_one_loop;
      logic ain_two_loop;
      logic ain_one_lost;
      logic ain_two_lost;
   } io_cond_t;

   // speed, current, power, torque already in tenths
   typedef struct packed {
      logic [15:0] speed;
      logic [15:0] setpoint;
      logic [15:0] current;
      logic [15:0] power;
      logic [15:0] torque;
      logic [15:0] bus_volt;
      logic [15:0] heatsink;
      logic [15:0] ain_one;
      logic [15:0] ain_two;
      logic [15:0] aout;
      logic [15:0] loop_out;
      logic [15:0] board_temp;
      logic [15:0] motor_volt;
      logic [15:0] knob;
      logic [15:0] fault;
   } meas_t;

   typedef struct packed {
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] wdata;
   } req_t;

   typedef struct packed {
      logic [15:0] data;
      logic [7:0] exc;
   } rsp_t;
endpackage

// ### tb/drive_regs_chk.sv
// port checker for the drive status register bank
// bound to every instance; one clock, async reset high
`timescale 1ns/1ps
module drive_regs_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // request and answer
   input wire logic req_valid,
   input wire drive_regs_pkg::req_t req,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire drive_regs_pkg::rsp_t rsp,
   // drive inputs
   input wire drive_regs_pkg::drive_cond_t drive_cond,
   input wire drive_regs_pkg::meas_t meas
);
   import drive_regs_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire logic rd_ds = req_valid && req.func == FC_READ
      && req.addr == REG_DRIVE_STATE;
   // params 4 to 60 only
   wire logic wr_par = req_valid && req.func == FC_WRITE
      && req.addr >= 16'h0084 && req.addr <= 16'h00BC;
   wire logic bad_fn = req_valid && req.func != FC_READ
      && req.func != FC_WRITE;
   property p_ready;
      req_ready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   property p_answer;
      req_valid |=> rsp_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_quiet;
      !req_valid |=> !rsp_valid;
   endproperty
   a_quiet: assert property (p_quiet) else $error("stray answer");
   property p_bad_func;
      bad_fn |=> rsp.exc == EXC_BAD_FUNC;
   endproperty
   a_bad_func: assert property (p_bad_func) else $error("func");
   property p_ready_bit;
      rd_ds |=> rsp.data[DS_READY] == (!$past(drive_cond.tripped)
         && !$past(drive_cond.supply_loss) && $past(drive_cond.hw_enable));
   endproperty
   a_ready_bit: assert property (p_ready_bit) else $error("ready");
   property p_heat;
      rd_ds |=> rsp.data[DS_HEATSINK_HOT]
         == ($past(meas.heatsink) > HEATSINK_LIMIT);
   endproperty
   a_heat: assert property (p_heat) else $error("heatsink bit");
   property p_reverse;
      rd_ds |=> rsp.data[DS_REVERSE] == $past(meas.speed[15]);
   endproperty
   a_reverse: assert property (p_reverse) else $error("reverse");
   property p_rsvd;
      rd_ds |=> !rsp.data[5] && !rsp.data[14];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit");
   property p_echo;
      wr_par |=> rsp.exc == EXC_NONE && rsp.data == $past(req.wdata);
   endproperty
   a_echo: assert property (p_echo) else $error("write echo");
   c_state: cover property (rd_ds ##1 rsp_valid);
   c_write: cover property (wr_par ##1 rsp_valid);
   c_bad: cover property (bad_fn ##1 rsp_valid);
endmodule

bind drive_status_register_map drive_regs_chk drive_regs_chk_inst (
   .ref_clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp,
   .drive_cond, .meas);

// ### tb/modbus_master_model.sv
// master side model: one register request, answer collected
// drives on falling edges; answer latency fixed at one cycle
`timescale 1ns/1ps
module modbus_master_model (
   // clock
   input wire logic ref_clk,
   // request out
   output logic req_valid,
   output drive_regs_pkg::req_t req,
   // answer in
   input wire logic rsp_valid,
   input wire drive_regs_pkg::rsp_t rsp
);
   import drive_regs_pkg::*;
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   task automatic xfer(input logic [7:0] f, input logic [15:0] a, w,
         output rsp_t r, output logic ok);
      @(negedge ref_clk);
      req_valid = 1'b1;
      req = '{func: f, addr: a, wdata: w};
      @(posedge ref_clk);
      @(negedge ref_clk);
      req_valid = 1'b0;
      // released lines must not keep the old value
      req = ~req;
      ok = rsp_valid;
      r = rsp;
   endtask
endmodule

// ### tb/test_drive_status_register_map.sv
// self-checking bench for the drive status register bank
// all register traffic goes through the master model
`timescale 1ns/1ps
module test_drive_status_register_map;
   import drive_regs_pkg::*;
   logic ref_clk, rst, req_valid, req_ready, rsp_valid, ok, tgl;
   req_t req;
   rsp_t rsp, r;
   drive_cond_t drive_cond;
   io_cond_t io_cond;
   meas_t meas;
   logic [15:0] minimum_speed_param;
   logic [5:0] pins;
   int err_total, checks;
   drive_status_register_map drive_status_register_map_inst (
      .ref_clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp,
      .drive_cond, .io_cond, .meas, .minimum_speed_param,
      .digital_input_one(pins[0]), .digital_input_two(pins[1]),
      .digital_input_three(pins[2]), .digital_input_four(pins[3]),
      .fwd_switch(pins[4]), .rev_switch(pins[5]));
   modbus_master_model modbus_master_model_inst (
      .ref_clk, .req_valid, .req, .rsp_valid, .rsp);
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic report_and_stop();
      $display("errors %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic xact(input logic [7:0] f, input logic [15:0] a, w);
      modbus_master_model_inst.xfer(f, a, w, r, ok);
      if (ok !== 1'b1) begin
         err_total++;
         $display("Error answer expected 1 seen %b", ok);
         report_and_stop();
      end
   endtask
   task automatic t_params();
      xact(FC_WRITE, 16'h0084, 16'hA5C3);
      chk("echo p4", 16'hA5C3, r.data);
      xact(FC_WRITE, 16'h00BC, 16'h5A3C);
      xact(FC_WRITE, 16'h0088, 16'h0010);
      xact(FC_READ, 16'h0084, 16'h0000);
      chk("read p4", 16'hA5C3, r.data);
      xact(FC_READ, 16'h00BC, 16'h0000);
      chk("read p60", 16'h5A3C, r.data);
      xact(FC_WRITE, 16'h00BD, 16'h1111);
      chk("exc p61", 16'h0002, {8'h00, r.exc});
      xact(FC_READ, 16'h0083, 16'h0000);
      chk("exc p3", 16'h0002, {8'h00, r.exc});
   endtask
   task automatic t_refuse();
      xact(FC_WRITE_MULTI, 16'h0084, 16'h0000);
      chk("exc multi", 16'h0001, {8'h00, r.exc});
      xact(FC_WRITE, REG_PIN_STATE, 16'hFFFF);
      chk("exc ro", 16'h0000, {8'h00, r.exc});
      chk("echo ro", 16'hFFFF, r.data);
      xact(FC_READ, 16'h0000, 16'h0000);
      chk("unmapped", 16'h0000, r.data);
      chk("exc unmapped", 16'h0002, {8'h00, r.exc});
   endtask
   // toggle bit tracked across every state read
   task automatic t_state(input drive_cond_t c,
         input logic [15:0] s, h, b, i, e);
      @(negedge ref_clk);
      drive_cond = c;
      meas.speed = s;
      meas.heatsink = h;
      meas.board_temp = b;
      meas.current = i;
      xact(FC_READ, REG_DRIVE_STATE, 16'h0000);
      chk("drive state", {tgl, e[14:0]}, r.data);
      tgl = ~tgl;
   endtask
   // pins pass a three-stage filter, six cycles is ample
   task automatic t_pins(input logic [5:0] p, io,
         input logic [15:0] ao, k, e);
      @(negedge ref_clk);
      pins = p;
      io_cond = io;
      meas.aout = ao;
      meas.knob = k;
      repeat (6) @(negedge ref_clk);
      xact(FC_READ, REG_PIN_STATE, 16'h0000);
      chk("pin state", e, r.data);
   endtask
   task automatic rd_chk(input string nm, input logic [15:0] a, e);
      xact(FC_READ, a, 16'h0000);
      chk(nm, e, r.data);
   endtask
   // mid-run reset must clear parameters and the alive bit
   task automatic t_reset();
      @(negedge ref_clk);
      rst = 1'b1;
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      rd_chk("p8 after reset", 16'h0088, PARAM_RESET);
      xact(FC_READ, REG_DRIVE_STATE, 16'h0000);
      chk("alive bit", 16'h0000, {15'h0000, r.data[DS_TOGGLE]});
      xact(FC_READ, REG_DRIVE_STATE, 16'h0000);
      chk("alive bit", 16'h0001, {15'h0000, r.data[DS_TOGGLE]});
   endtask
   task automatic t_meas();
      @(negedge ref_clk);
      meas.speed = 16'h01F4;
      meas.current = 16'h0037;
      meas.power = 16'h000F;
      meas.torque = 16'h07D0;
      meas.bus_volt = 16'h0159;
      meas.heatsink = 16'h002A;
      meas.ain_one = 16'h0FFF;
      meas.ain_two = 16'h0800;
      meas.aout = 16'h03E8;
      meas.loop_out = 16'h01C2;
      meas.board_temp = 16'h0031;
      meas.motor_volt = 16'h00E6;
      meas.knob = 16'h0ABC;
      meas.fault = 16'h0013;
      rd_chk("torque", REG_TORQUE, 16'h07D0);
      rd_chk("bus volt", REG_BUS_VOLT, 16'h0159);
      rd_chk("heatsink", REG_HEATSINK, 16'h002A);
      rd_chk("ain one", REG_AIN_ONE, 16'h0FFF);
      rd_chk("ain two", REG_AIN_TWO, 16'h0800);
      rd_chk("aout", REG_AOUT, 16'h03E8);
      rd_chk("loop out", REG_LOOP_OUT, 16'h01C2);
      rd_chk("board temp", REG_BOARD_TEMP, 16'h0031);
      rd_chk("motor volt", REG_MOTOR_VOLT, 16'h00E6);
      rd_chk("knob", REG_KNOB, 16'h0ABC);
      rd_chk("fault", REG_FAULT, 16'h0013);
      xact(FC_READ, REG_SPEED, 16'h0000);
      chk("speed", 16'h01F4, r.data);
      xact(FC_READ, REG_CURRENT, 16'h0000);
      chk("current", 16'h0037, r.data);
      xact(FC_READ, REG_POWER, 16'h0000);
      chk("power", 16'h000F, r.data);
   endtask
   initial begin
      err_total = 0;
      checks = 0;
      tgl = 1'b0;
      rst = 1'b1;
      drive_cond = '0;
      io_cond = '0;
      meas = '0;
      meas.setpoint = 16'h0064;
      minimum_speed_param = 16'h000A;
      pins = '0;
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      t_params();
      t_refuse();
      t_state(8'h20, 16'h0064, 16'h0055, 16'h0050, 16'h0010,
         16'h0001);
      t_state(8'hFF, 16'h0064, 16'h0055, 16'h0050, 16'h0000,
         16'h125E);
      t_state(8'h22, 16'hFFFB, 16'h0056, 16'h0051, 16'h0011,
         16'h2D81);
      t_pins(6'h3F, 6'h3F, 16'h0000, 16'h0801,
         16'hB3CF);
      t_pins(6'h25, 6'h0C, 16'h0001, 16'h0800,
         16'h0185);
      t_pins(6'h10, 6'h03, 16'h0000, 16'h0000, 16'h0040);
      t_meas();
      t_reset();
      report_and_stop();
   end
endmodule
